/* bench/core_model.sv */
// Behavioural model of the instruction core feeding the register group
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Core model
module core_model (
  input  wire logic                    i_ref_clk,
  input  wire logic [7:0]              i_rdata,
  output var  sysreg_pkg::reg_access_t o_access,
  output var  sysreg_pkg::alu_result_t o_alu,
  output var  sysreg_pkg::carry_op_t   o_carry_op,
  output var  sysreg_pkg::int_event_t  o_int_evt
);
  import sysreg_pkg::*;
  initial begin
    o_access = '0;
    o_alu = '0;
    o_carry_op = CARRY_NONE;
    o_int_evt = '0;
  end
  // Address is kept after a write so the read path stays defined
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    o_access <= '{wr: 1'b1, addr: a, wdata: d};
    @(posedge i_ref_clk);
    o_access.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    o_access <= '{wr: 1'b0, addr: a, wdata: 8'h00};
    repeat (2) @(posedge i_ref_clk);
    #1 d = i_rdata;
  endtask
  task automatic evt(input int_event_t e);
    @(posedge i_ref_clk);
    o_int_evt <= e;
    @(posedge i_ref_clk);
    o_int_evt <= '0;
  endtask
  task automatic alu(input alu_result_t r);
    @(posedge i_ref_clk);
    o_alu <= r;
    @(posedge i_ref_clk);
    o_alu <= '0;
  endtask
  task automatic carry(input carry_op_t c);
    @(posedge i_ref_clk);
    o_carry_op <= c;
    @(posedge i_ref_clk);
    o_carry_op <= CARRY_NONE;
  endtask
endmodule
`default_nettype wire

/* bench/sysreg_assertions.sv */
// Port checker for the system register group
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Checker
module sysreg_checker (
  input wire logic                    i_ref_clk,
  input wire logic                    i_rst_n,
  input wire sysreg_pkg::reg_access_t i_access,
  input wire sysreg_pkg::alu_result_t i_alu,
  input wire sysreg_pkg::carry_op_t   i_carry_op,
  input wire sysreg_pkg::int_event_t  i_int_evt,
  input wire logic                    i_set_data_space,
  input wire logic                    i_nonmask_ctl,
  input wire logic                    i_timer_count_en,
  input wire logic [7:0]              o_rdata,
  input wire logic [7:0]              o_int_ctl,
  input wire logic [7:0]              o_flags,
  input wire logic [2:0]              o_nested_store,
  input wire logic                    o_timer_enable,
  input wire logic                    o_top_ack_allowed,
  input wire logic                    o_data_space
);
  import sysreg_pkg::*;
  logic in_rst;
  // Outputs settle one edge into reset, so only judge from the second edge
  always_ff @(posedge i_ref_clk) begin
    in_rst <= !i_rst_n;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  a_reset_vals: assert property (disable iff (1'b0)
    in_rst |-> o_int_ctl == 8'h87 && o_flags == 8'h00) else $error("bad reset value");
  a_timer_gate: assert property (
    o_timer_enable == (o_int_ctl[7] && $past(i_timer_count_en))) else $error("timer gate");
  a_pend_set: assert property (
    i_int_evt.top_request |-> ##2 o_int_ctl[6]) else $error("pending not set");
  a_top_ack: assert property (
    o_top_ack_allowed == (o_int_ctl[6] && $past(i_nonmask_ctl) && (!o_int_ctl[5] || o_int_ctl[4])))
    else $error("top ack gating");
  a_ack_clears_en: assert property (
    i_int_evt.acknowledge |-> ##2 !o_int_ctl[4]) else $error("enable kept on ack");
  a_iret_sets_en: assert property (
    i_int_evt.iret && !i_int_evt.acknowledge |-> ##2 o_int_ctl[4]) else $error("enable on return");
  a_ack_level: assert property (
    i_int_evt.acknowledge |-> ##2 o_int_ctl[2:0] == $past(i_int_evt.new_level, 2))
    else $error("level not loaded");
  a_preempt_save: assert property (
    i_int_evt.acknowledge && i_int_evt.preempt ##1 $past(i_int_evt.new_level) < o_int_ctl[2:0]
    |-> ##1 o_nested_store == $past(o_int_ctl[2:0])) else $error("level not saved");
  a_flag_rsvd: assert property (!o_flags[1]) else $error("reserved flag set");
  a_carry_set: assert property (
    i_carry_op == CARRY_SET && !i_access.wr && !i_int_evt.iret |-> ##2 o_flags[7])
    else $error("carry not set");
  a_zero_sign: assert property (
    i_alu.valid && !i_alu.word && i_carry_op == CARRY_NONE && !i_access.wr && !i_int_evt.iret
    |-> ##2 o_flags[6:5] == {$past(i_alu.result[7:0], 2) == 8'h00, $past(i_alu.result[7], 2)})
    else $error("zero or sign wrong");
  a_space_set: assert property (
    i_set_data_space && !i_access.wr && !i_int_evt.iret |-> ##2 o_data_space && o_flags[0])
    else $error("data space not set");
  a_ptr_low_zero: assert property (
    $past(i_access.addr) == ADDR_WP_LOW |-> o_rdata[1:0] == 2'h0) else $error("pointer low bits");
  c_preempt: cover property (i_int_evt.acknowledge && i_int_evt.preempt);
  c_top_ack: cover property (o_top_ack_allowed);
  c_toggle: cover property (i_carry_op == CARRY_TOGGLE);
endmodule

bind system_control_registers sysreg_checker sysreg_checker_inst (
  .i_ref_clk, .i_rst_n, .i_access, .i_alu, .i_carry_op, .i_int_evt, .i_set_data_space,
  .i_nonmask_ctl, .i_timer_count_en, .o_rdata, .o_int_ctl, .o_flags, .o_nested_store,
  .o_timer_enable, .o_top_ack_allowed, .o_data_space
);
`default_nettype wire

/* bench/system_control_registers_tb.sv */
// Self-checking testbench for the system register group
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Bench
module system_control_registers_tb;
  import sysreg_pkg::*;
  logic        clk, rst_n, set_data, set_prog, nonmask, count_en;
  logic        set_single, set_low, set_high, timer_en, ack_ok, data_space;
  logic [4:0]  ptr_block;
  logic [3:0]  work_reg;
  logic [7:0]  rdata, int_ctl, flags, work_addr, d;
  logic [2:0]  nested;
  reg_access_t access;
  alu_result_t alu;
  carry_op_t   carry_op;
  int_event_t  int_evt;
  int          bad_count, tests_run;

  system_control_registers system_control_registers_inst (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_access(access), .i_alu(alu),
    .i_carry_op(carry_op), .i_int_evt(int_evt), .i_set_data_space(set_data),
    .i_set_program_space(set_prog), .i_nonmask_ctl(nonmask), .i_timer_count_en(count_en),
    .i_set_single_ptr(set_single), .i_set_twin_low(set_low), .i_set_twin_high(set_high),
    .i_ptr_block(ptr_block), .i_work_reg(work_reg), .o_rdata(rdata), .o_int_ctl(int_ctl),
    .o_flags(flags), .o_nested_store(nested), .o_timer_enable(timer_en),
    .o_top_ack_allowed(ack_ok), .o_data_space(data_space), .o_work_addr(work_addr));
  core_model core_model_inst (
    .i_ref_clk(clk), .i_rdata(rdata), .o_access(access),
    .o_alu(alu), .o_carry_op(carry_op), .o_int_evt(int_evt));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    core_model_inst.rd(a, d);
    check(d, e);
  endtask
  function automatic alu_result_t mk(logic w, logic [15:0] r, logic c, logic v, logic h, logic s);
    mk = '{valid: 1'b1, word: w, result: r, carry_out: c, overflow: v, half_carry: h,
           arith: 1'b1, is_sub: s, affects_carry: 1'b1};
  endfunction
  task automatic t_reset();
    step(1);
    check(int_ctl, 8'h87);
    check({5'h00, nested}, 8'h07);
    rchk(8'hE6, 8'h87);
    rchk(8'hE7, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_timer();
    @(posedge clk);
    count_en <= 1'b1;
    step(2);
    check({7'h00, timer_en}, 8'h01);
    core_model_inst.wr(8'hE6, 8'h07); // Enable left clear while writing
    step(1);
    check({7'h00, timer_en}, 8'h00);
    core_model_inst.wr(8'hE6, 8'h87);
    step(1);
    check({7'h00, timer_en}, 8'h01);
    $display("test timer done");
  endtask
  task automatic t_space();
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      set_data <= (i != 1); // Passes 0 and 2 select data space, pass 1 program space
      set_prog <= (i == 1);
      @(posedge clk);
      set_data <= 1'b0;
      set_prog <= 1'b0;
      step(1);
      check(flags, (i == 1) ? 8'h00 : 8'h01);
      check({7'h00, data_space}, (i == 1) ? 8'h00 : 8'h01);
    end
    $display("test space done");
  endtask
  task automatic t_int();
    @(posedge clk);
    nonmask <= 1'b1;
    core_model_inst.evt(int_event_t'(9'h100));
    step(1);
    check(int_ctl, 8'hC7);
    check({7'h00, ack_ok}, 8'h01);
    core_model_inst.wr(8'hE6, 8'hE7);
    step(1);
    check({7'h00, ack_ok}, 8'h00);
    core_model_inst.evt(int_event_t'(9'h002));
    step(1);
    check(int_ctl, 8'hF7);
    check({7'h00, ack_ok}, 8'h01);
    core_model_inst.evt(int_event_t'(9'h0A8));
    step(1);
    check(int_ctl, 8'hE5);
    core_model_inst.evt(int_event_t'(9'h0D0));
    step(1);
    check({5'h00, nested}, 8'h05);
    check(int_ctl, 8'hE2);
    core_model_inst.evt(int_event_t'(9'h004));
    step(1);
    check(int_ctl & 8'h10, 8'h10);
    core_model_inst.evt(int_event_t'(9'h001));
    core_model_inst.wr(8'hE6, 8'h48);
    core_model_inst.rd(8'hE6, d);
    check(d & 8'h5F, 8'h48);
    $display("test interrupt done");
  endtask
  task automatic t_flags();
    carry_op_t  ops[4] = '{CARRY_SET, CARRY_TOGGLE, CARRY_TOGGLE, CARRY_CLEAR};
    logic [7:0] fx[4] = '{8'h81, 8'h01, 8'h81, 8'h01};
    core_model_inst.wr(8'hE7, 8'hFF);
    step(1);
    check(flags, 8'hFD);
    core_model_inst.wr(8'hE7, 8'h01);
    for (int i = 0; i < 4; i++) begin
      core_model_inst.carry(ops[i]);
      step(1);
      check(flags, fx[i]);
    end
    core_model_inst.alu(mk(1'b0, 16'h0080, 1'b1, 1'b1, 1'b1, 1'b0));
    step(1);
    check(flags, 8'hB5);
    core_model_inst.alu(mk(1'b0, 16'hFF00, 1'b0, 1'b0, 1'b0, 1'b1));
    step(1);
    check(flags, 8'h49);
    core_model_inst.alu(mk(1'b1, 16'h8000, 1'b1, 1'b0, 1'b0, 1'b0));
    step(1);
    check(flags & 8'hF0, 8'hA0);
    core_model_inst.wr(8'hE7, 8'h81);
    core_model_inst.evt(int_event_t'(9'h088));
    core_model_inst.alu(mk(1'b0, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b1));
    core_model_inst.evt(int_event_t'(9'h004));
    step(1);
    check(flags, 8'h81);
    $display("test flags done");
  endtask
  task automatic t_ptr();
    @(posedge clk);
    set_single <= 1'b1;
    ptr_block <= 5'h03;
    work_reg <= 4'h5;
    @(posedge clk);
    set_single <= 1'b0;
    step(2);
    check(work_addr, 8'h15);
    core_model_inst.rd(8'hE8, d);
    check(d & 8'h07, 8'h00);
    @(posedge clk);
    set_low <= 1'b1;
    ptr_block <= 5'h04;
    work_reg <= 4'h3;
    @(posedge clk);
    set_low <= 1'b0;
    set_high <= 1'b1;
    ptr_block <= 5'h09;
    @(posedge clk);
    set_high <= 1'b0;
    step(2);
    check(work_addr, 8'h23);
    @(posedge clk);
    work_reg <= 4'hC;
    step(2);
    check(work_addr, 8'h4C);
    rchk(8'hE8, 8'h24);
    rchk(8'hE9, 8'h4C);
    core_model_inst.wr(8'hE8, 8'hFF);
    rchk(8'hE8, 8'hFC);
    rchk(8'h10, 8'h00);
    $display("test pointers done");
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    stop_test();
  end
  initial begin
    {rst_n, set_data, set_prog, nonmask, count_en, set_single, set_low, set_high} = 8'h00;
    ptr_block = 5'h00;
    work_reg = 4'h0;
    bad_count = 0;
    tests_run = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_timer();
    t_space();
    t_int();
    t_flags();
    t_ptr();
    stop_test();
  end
endmodule
`default_nettype wire

/* rtl/sysreg_pkg.sv */
// Package: offsets, field positions, reset values and operation codes of the system registers
package sysreg_pkg;

  // ==========================================================================
  // Register addresses
  localparam logic [7:0] ADDR_INT_CTL   = 8'hE6;
  localparam logic [7:0] ADDR_FLAGS     = 8'hE7;
  localparam logic [7:0] ADDR_WP_LOW    = 8'hE8;
  localparam logic [7:0] ADDR_WP_HIGH   = 8'hE9;
  localparam logic [7:0] ADDR_PAGE_SEL  = 8'hEA;
  localparam logic [7:0] ADDR_MODE_CTL  = 8'hEB;
  localparam logic [7:0] ADDR_USP_HIGH  = 8'hEC;
  localparam logic [7:0] ADDR_USP_LOW   = 8'hED;
  localparam logic [7:0] ADDR_SSP_HIGH  = 8'hEE;
  localparam logic [7:0] ADDR_SSP_LOW   = 8'hEF;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] INT_CTL_RESET  = 8'h87;
  localparam logic [7:0] FLAGS_RESET    = 8'h00;
  localparam logic [7:0] WP_RESET       = 8'h00;

  // ==========================================================================
  // Interrupt control field positions
  localparam int ICB_TIMER_RUN = 7;
  localparam int ICB_TOP_PEND  = 6;
  localparam int ICB_TOP_GATE  = 5;
  localparam int ICB_IEN       = 4;
  localparam int ICB_ARB_MODE  = 3;

  // Flag field positions
  localparam int FB_CARRY = 7;
  localparam int FB_ZERO  = 6;
  localparam int FB_SIGN  = 5;
  localparam int FB_OVF   = 4;
  localparam int FB_BCD   = 3;
  localparam int FB_HALF  = 2;
  localparam int FB_RSVD  = 1;
  localparam int FB_DATA  = 0;

  // Pointer field positions
  localparam int WPB_MODE = 2;

  localparam int SAVE_DEPTH = 7;
  localparam int SAVE_IDX_W = 3;

  // ==========================================================================
  // Carry operations from the core
  typedef enum logic [1:0] {
    CARRY_NONE,
    CARRY_SET,
    CARRY_CLEAR,
    CARRY_TOGGLE
  } carry_op_t;

  // Result of an ALU operation presented for flag update
  typedef struct packed {
    logic        valid;
    logic        word;
    logic [15:0] result;
    logic        carry_out;
    logic        overflow;
    logic        half_carry;
    logic        arith;
    logic        is_sub;
    logic        affects_carry;
  } alu_result_t;

  // Interrupt events from the core
  typedef struct packed {
    logic       top_request;
    logic       acknowledge;
    logic       preempt;
    logic [2:0] new_level;
    logic       iret;
    logic       unmask;
    logic       mask;
  } int_event_t;

  // Register access from the core
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_t;

endpackage

/* rtl/system_control_registers.sv */
// System register group: interrupt control, CPU flags and working-register pointers
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// [RULE1] Interrupt control resets to 87h
// [RULE2] Timer runs when global and own enable
// [RULE3] Top-level pending set by hardware or write
// [RULE4] Top-level ack gated by enable when selected
// [RULE5] Enable cleared by ack, set by return
// [RULE6] Software masks before writing interrupt control
// [RULE7] Arbitration mode bit: 0 concurrent, 1 nested; bit 3 is only stored here, and no logic reads it
// [RULE8] Priority level 000 highest, compared for preemption
// [RULE9] Preempted level saved in nested store
// [RULE10] Flags saved on interrupt, up to seven
// [RULE11] Flags reset to 00h, bit 1 zero
// [RULE12] Carry from bit 7/15, set/clear/complement
// [RULE13] Zero flag set when result zero
// [RULE14] Sign flag is result top bit
// [RULE15] Overflow flag on two's complement overflow
// [RULE16] BCD flag records add or subtract
// [RULE17] Half carry from bit 3
// [RULE18] Data space flag set/cleared by instructions
// [RULE19] Software keeps data space flag set
// [RULE20] Single or twin mode over 32 blocks
// [RULE21] Single mode rounds block down to even
// [RULE22] Twin mode splits r0-7 and r8-15
// [RULE23] Pointer bits 7:3 block, 2 mode, 1:0 zero
// [RULE24] Twin ops set mode bit, single clears
// [RULE25] Address is block times eight plus offset
module system_control_registers (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst_n,
  input  wire sysreg_pkg::reg_access_t i_access,
  input  wire sysreg_pkg::alu_result_t i_alu,
  input  wire sysreg_pkg::carry_op_t   i_carry_op,
  input  wire sysreg_pkg::int_event_t  i_int_evt,
  input  wire logic                  i_set_data_space,
  input  wire logic                  i_set_program_space,
  input  wire logic                  i_nonmask_ctl,
  input  wire logic                  i_timer_count_en,
  input  wire logic                  i_set_single_ptr,
  input  wire logic                  i_set_twin_low,
  input  wire logic                  i_set_twin_high,
  input  wire logic [4:0]            i_ptr_block,
  input  wire logic [3:0]            i_work_reg,
  output logic [7:0]                 o_rdata,
  output logic [7:0]                 o_int_ctl,
  output logic [7:0]                 o_flags,
  output logic [2:0]                 o_nested_store,
  output logic                       o_timer_enable,
  output logic                       o_top_ack_allowed,
  output logic                       o_data_space,
  output logic [7:0]                 o_work_addr
);
  import sysreg_pkg::*;

  // ==========================================================================
  // Storage
  logic [7:0] int_ctl_reg;
  logic [7:0] flags_reg;
  logic [7:0] wp_low_reg;
  logic [7:0] wp_high_reg;
  logic [7:0] page_sel_reg;
  logic [7:0] mode_ctl_reg;
  logic [7:0] usp_high_reg;
  logic [7:0] usp_low_reg;
  logic [7:0] ssp_high_reg;
  logic [7:0] ssp_low_reg;
  logic [2:0] nested_reg;
  logic [7:0] flag_save_reg [SAVE_DEPTH];
  logic [SAVE_IDX_W-1:0] save_cnt_reg;

  logic       wr_int_ctl;
  logic       wr_flags;
  logic       wr_wp_low;
  logic       wr_wp_high;
  logic [7:0] flags_next;
  logic [7:0] rdata_next;
  logic [7:0] work_addr_next;
  logic [15:0] res;
  logic        res_zero;
  logic        res_sign;
  logic        save_full;
  logic        save_empty;
  logic        push_flags;
  logic        pop_flags;
  logic        preempt_hit;
  logic        twin_mode;

  assign wr_int_ctl = i_access.wr && (i_access.addr == ADDR_INT_CTL);
  assign wr_flags   = i_access.wr && (i_access.addr == ADDR_FLAGS);
  assign wr_wp_low  = i_access.wr && (i_access.addr == ADDR_WP_LOW);
  assign wr_wp_high = i_access.wr && (i_access.addr == ADDR_WP_HIGH);

  // Event qualifiers shared by the interrupt, flag and pointer logic
  assign save_full   = (save_cnt_reg == 3'(SAVE_DEPTH));
  assign save_empty  = (save_cnt_reg == '0);
  assign push_flags  = i_int_evt.acknowledge && !save_full;
  assign pop_flags   = i_int_evt.iret && !save_empty;
  assign preempt_hit = i_int_evt.acknowledge && i_int_evt.preempt &&
                       (i_int_evt.new_level < int_ctl_reg[2:0]);
  assign twin_mode   = wp_low_reg[WPB_MODE];

  // ==========================================================================
  // Interrupt control
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      int_ctl_reg <= INT_CTL_RESET; // [RULE1]
    end else begin
      if (wr_int_ctl) begin
        // Caller masks first, so a plain write is safe [RULE6]
        int_ctl_reg <= i_access.wdata; // [RULE7]
      end
      // Later lines win: mask, then unmask or return, then acknowledge
      if (i_int_evt.mask) begin
        int_ctl_reg[ICB_IEN] <= 1'b0; // [RULE5]
      end
      if (i_int_evt.unmask || i_int_evt.iret) begin
        int_ctl_reg[ICB_IEN] <= 1'b1; // [RULE5]
      end
      if (i_int_evt.acknowledge) begin
        int_ctl_reg[ICB_IEN] <= 1'b0; // [RULE5]
        int_ctl_reg[2:0]     <= i_int_evt.new_level; // [RULE8]
      end
      // Hardware set wins over a clearing write
      if (i_int_evt.top_request) begin
        int_ctl_reg[ICB_TOP_PEND] <= 1'b1; // [RULE3]
      end
    end
  end

  // Preempted level kept for restore by the core
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      nested_reg <= 3'h7;
    end else if (preempt_hit) begin
      nested_reg <= int_ctl_reg[2:0]; // [RULE9] [RULE8]
    end
  end

  // Gate only; the timer's own enable is kept in the timer itself
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_timer_enable <= 1'b0;
    end else begin
      o_timer_enable <= int_ctl_reg[ICB_TIMER_RUN] & i_timer_count_en; // [RULE2]
    end
  end

  // Nonmask control always gates; the enable only when the gate bit asks
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_top_ack_allowed <= 1'b0;
    end else begin
      o_top_ack_allowed <= int_ctl_reg[ICB_TOP_PEND] & i_nonmask_ctl &
          (~int_ctl_reg[ICB_TOP_GATE] | int_ctl_reg[ICB_IEN]); // [RULE4]
    end
  end

  // ==========================================================================
  // Flag computation
  assign res      = i_alu.word ? i_alu.result : {8'h00, i_alu.result[7:0]};
  assign res_zero = (res == 16'h0000);
  assign res_sign = i_alu.word ? i_alu.result[15] : i_alu.result[7];

  always_comb begin
    flags_next = flags_reg;
    // Later lines win: ALU, carry op, space op, write, then restore
    if (i_alu.valid) begin
      if (i_alu.affects_carry) begin
        flags_next[FB_CARRY] = i_alu.carry_out; // [RULE12]
      end
      flags_next[FB_ZERO] = res_zero;      // [RULE13]
      flags_next[FB_SIGN] = res_sign;      // [RULE14]
      flags_next[FB_OVF]  = i_alu.overflow; // [RULE15]
      if (i_alu.arith) begin
        flags_next[FB_BCD] = i_alu.is_sub; // [RULE16]
        if (!i_alu.word) begin
          flags_next[FB_HALF] = i_alu.half_carry; // [RULE17]
        end
      end
    end
    case (i_carry_op)
      CARRY_SET:    flags_next[FB_CARRY] = 1'b1; // [RULE12]
      CARRY_CLEAR:  flags_next[FB_CARRY] = 1'b0;
      CARRY_TOGGLE: flags_next[FB_CARRY] = ~flags_reg[FB_CARRY];
      default:      flags_next[FB_CARRY] = flags_next[FB_CARRY];
    endcase
    if (i_set_data_space) begin
      flags_next[FB_DATA] = 1'b1; // [RULE18]
    end else if (i_set_program_space) begin
      flags_next[FB_DATA] = 1'b0; // [RULE18]
    end
    if (wr_flags) begin
      flags_next = i_access.wdata;
    end
    if (pop_flags) begin
      flags_next = flag_save_reg[save_cnt_reg - 3'd1]; // [RULE10]
    end
    flags_next[FB_RSVD] = 1'b0; // [RULE11]
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      flags_reg <= FLAGS_RESET; // [RULE11]
    end else begin
      flags_reg <= flags_next;
    end
  end

  // ==========================================================================
  // Flag save stack, one entry per nesting level
  // A full stack drops the push; an empty one ignores a return
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      save_cnt_reg <= '0;
    end else if (push_flags) begin
      save_cnt_reg <= save_cnt_reg + 3'd1; // [RULE10]
    end else if (pop_flags) begin
      save_cnt_reg <= save_cnt_reg - 3'd1;
    end
  end

  generate
    for (genvar g = 0; g < SAVE_DEPTH; g++) begin : g_save
      // Slot g takes the flags while it is the next free one
      always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
          flag_save_reg[g] <= FLAGS_RESET;
        end else if (push_flags && (save_cnt_reg == 3'(g))) begin
          flag_save_reg[g] <= flags_reg; // [RULE10]
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Working-register pointers
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      wp_low_reg  <= WP_RESET; // [RULE23]
      wp_high_reg <= WP_RESET;
    end else begin
      if (i_set_single_ptr) begin
        wp_low_reg  <= {i_ptr_block, 3'b000}; // [RULE20] [RULE24]
        wp_high_reg[WPB_MODE] <= 1'b0;
      end else if (i_set_twin_low) begin
        // Both pointers carry the mode bit, so either reads it back
        wp_low_reg  <= {i_ptr_block, 3'b100}; // [RULE24]
        wp_high_reg[WPB_MODE] <= 1'b1;
      end else if (i_set_twin_high) begin
        wp_high_reg <= {i_ptr_block, 3'b100}; // [RULE24]
        wp_low_reg[WPB_MODE] <= 1'b1;
      end else begin
        if (wr_wp_low) begin
          wp_low_reg <= {i_access.wdata[7:2], 2'b00}; // [RULE23]
        end
        if (wr_wp_high) begin
          wp_high_reg <= {i_access.wdata[7:2], 2'b00};
        end
      end
    end
  end

  // Block number times eight plus offset
  always_comb begin
    if (!twin_mode) begin
      // Block bit 0 dropped: a 16-register group starts on an even block
      work_addr_next = {wp_low_reg[7:4], i_work_reg}; // [RULE21] [RULE25]
    end else if (!i_work_reg[3]) begin
      work_addr_next = {wp_low_reg[7:3], i_work_reg[2:0]}; // [RULE22]
    end else begin
      work_addr_next = {wp_high_reg[7:3], i_work_reg[2:0]}; // [RULE22]
    end
  end

  // ==========================================================================
  // Other system registers, plain storage except page select, which holds bits 1:0 at zero
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      page_sel_reg <= 8'h00;
      mode_ctl_reg <= 8'h00;
    end else if (i_access.wr) begin
      if (i_access.addr == ADDR_PAGE_SEL) begin
        page_sel_reg <= {i_access.wdata[7:2], 2'b00};
      end else if (i_access.addr == ADDR_MODE_CTL) begin
        mode_ctl_reg <= i_access.wdata;
      end
    end
  end

  // Stack pointers are plain storage here; pushes and pops step them in the core
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      usp_high_reg <= 8'h00;
      usp_low_reg  <= 8'h00;
      ssp_high_reg <= 8'h00;
      ssp_low_reg  <= 8'h00;
    end else if (i_access.wr) begin
      if (i_access.addr == ADDR_USP_HIGH) begin
        usp_high_reg <= i_access.wdata;
      end else if (i_access.addr == ADDR_USP_LOW) begin
        usp_low_reg <= i_access.wdata;
      end else if (i_access.addr == ADDR_SSP_HIGH) begin
        ssp_high_reg <= i_access.wdata;
      end else if (i_access.addr == ADDR_SSP_LOW) begin
        ssp_low_reg <= i_access.wdata;
      end
    end
  end

  // ==========================================================================
  // Read path, one cycle latency
  always_comb begin
    if (i_access.addr == ADDR_INT_CTL) begin
      rdata_next = int_ctl_reg;
    end else if (i_access.addr == ADDR_FLAGS) begin
      rdata_next = flags_reg;
    end else if (i_access.addr == ADDR_WP_LOW) begin
      rdata_next = wp_low_reg;
    end else if (i_access.addr == ADDR_WP_HIGH) begin
      rdata_next = wp_high_reg;
    end else if (i_access.addr == ADDR_PAGE_SEL) begin
      rdata_next = page_sel_reg;
    end else if (i_access.addr == ADDR_MODE_CTL) begin
      rdata_next = mode_ctl_reg;
    end else if (i_access.addr == ADDR_USP_HIGH) begin
      rdata_next = usp_high_reg;
    end else if (i_access.addr == ADDR_USP_LOW) begin
      rdata_next = usp_low_reg;
    end else if (i_access.addr == ADDR_SSP_HIGH) begin
      rdata_next = ssp_high_reg;
    end else if (i_access.addr == ADDR_SSP_LOW) begin
      rdata_next = ssp_low_reg;
    end else begin
      rdata_next = 8'h00;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= rdata_next;
    end
  end

  // Mirrors lag the registers by one cycle
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_int_ctl      <= INT_CTL_RESET;
      o_flags        <= FLAGS_RESET;
      o_nested_store <= 3'h7;
      o_data_space   <= 1'b0;
    end else begin
      o_int_ctl      <= int_ctl_reg;
      o_flags        <= flags_reg;
      o_nested_store <= nested_reg;
      o_data_space   <= flags_reg[FB_DATA]; // [RULE19]
    end
  end

  // Registered so the core sees a settled address for a whole cycle
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_work_addr <= 8'h00;
    end else begin
      o_work_addr <= work_addr_next;
    end
  end

endmodule
`default_nettype wire
